// ==== rtl/sadc_pkg.sv ====
// package for the simultaneous-sampling converter sequence control
// assumes a single 125 MHz core clock and pin inputs from off-chip
package sadc_pkg;
   localparam int NUM_CH = 4;
   localparam int DATA_W = 12;
   localparam int SEL_W = 4;
   localparam int FIFO_DEPTH = 16;
   // master clock cycles per single-channel conversion
   localparam int CONV_CYCLES = 14;
   localparam logic [4:0] CONV_LAST = 5'(CONV_CYCLES - 1);
   // end-of-conversion low pulse: 75 ns minimum at 8 ns per cycle
   localparam int EOC_MIN_NS = 75;
   localparam int CLK_PERIOD_NS = 8;
   localparam int EOC_CYCLES = (EOC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] EOC_LAST = 4'(EOC_CYCLES - 1);
   // internal master clock divider: last count value, so one tick every two core cycles
   localparam logic [3:0] INT_DIV_LAST = 4'h1;
   localparam logic [SEL_W-1:0] SEL_RESET = 4'hF;
   localparam logic [1:0] PTR_FIRST = 2'h0;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STORE} seq_state_t;
endpackage

// ==== rtl/sadc_sync.sv ====
// two-flip-flop synchroniser for a bundle of pin levels
// assumes inputs are asynchronous to core_clk_i
`timescale 1ns/1ps
module sadc_sync #(
   parameter int W = 1
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [W-1:0] async_i,
   input wire logic [W-1:0] reset_val_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta;
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         meta <= reset_val_i;
         sync_o <= reset_val_i;
      end
      else
      begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// ==== rtl/sadc_fifo.sv ====
// result FIFO with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/1ps
module sadc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;
   assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr != rd_ptr;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge core_clk_i)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data_i;
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i || flush_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

// ==== rtl/sadc_seq_ctrl.sv ====
// sequence control and parallel host port of a four-channel converter
// assumes pins arrive asynchronously; the analog core returns a sample
// for the channel named on conv_channel_o when conv_sample_o pulses
`timescale 1ns/1ps
// Operation
// - busy rises on the convert-start rising edge and stays high until all selected channels are done.
// - the first-result flag is high exactly while the read pointer selects result register 1.
// - a convert-start rising edge puts all four track/holds into hold and starts the conversions.
// - the channel selection is captured at the convert-start rising edge and kept for the sequence.
// - the block counts itself selected only while chip-select is low and ignores strobes otherwise.
// - the data bus is driven only while read strobe and chip-select are both low.
// - a write-strobe rising edge with chip-select low and read high stores the four low data lines.
// - with the select input at zero the sequence comes from the four hardware select pins.
// - with the select input at one the sequence comes from the software select register.
// - standby high means normal operation and standby low means power save.
// - select register bit 0 enables channel 1 up to bit 3 enabling channel 4.
// - each single-channel conversion takes fourteen master-clock cycles.
// - each finished conversion is marked by a low pulse on the end-of-conversion output.
// - the internal master clock is used when clock-source select is 0 and the external one when 1.
module sadc_seq_ctrl
   import sadc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic convert_start_n_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [sadc_pkg::SEL_W-1:0] hw_channel_select_i,
   input wire logic hw_sw_select_i,
   input wire logic standby_n_i,
   input wire logic clock_source_select_i,
   input wire logic external_conversion_clock_i,
   input wire logic [sadc_pkg::SEL_W-1:0] data_line_i,
   input wire logic [sadc_pkg::DATA_W-1:0] adc_result_i,
   output logic [sadc_pkg::DATA_W-1:0] data_line_o,
   output logic data_line_oe_n_o,
   output logic busy_o,
   output logic first_result_flag_o,
   output logic eoc_n_o,
   output logic hold_o,
   output logic conv_sample_o,
   output logic [1:0] conv_channel_o,
   output logic power_down_o
);
   import sadc_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   localparam int PW = 8 + SEL_W + SEL_W;
   logic [PW-1:0] pins_raw;
   logic [PW-1:0] pins_rst;
   logic [PW-1:0] pins;
   assign pins_raw = {convert_start_n_i, cs_n_i, rd_n_i, wr_n_i,
      hw_sw_select_i, standby_n_i, external_conversion_clock_i,
      clock_source_select_i, hw_channel_select_i, data_line_i};
   assign pins_rst = {4'hF, 4'h4, 8'h00};
   sadc_sync #(.W(PW)) u_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .async_i(pins_raw),
      .reset_val_i(pins_rst),
      .sync_o(pins)
   );
   logic cvs;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic hs_sel;
   logic standby_n_n;
   logic ext_clk;
   logic cks;
   logic [SEL_W-1:0] hw_sel;
   logic [SEL_W-1:0] dl;
   assign {cvs, cs_n, rd_n, wr_n, hs_sel, standby_n_n, ext_clk, cks, hw_sel,
      dl} = pins;

   logic cvs_q;
   logic wr_q;
   logic rd_q;
   logic ext_q;
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         cvs_q <= 1'b1;
         wr_q <= 1'b1;
         rd_q <= 1'b1;
         ext_q <= 1'b0;
      end
      else
      begin
         cvs_q <= cvs;
         wr_q <= wr_n;
         rd_q <= rd_n;
         ext_q <= ext_clk;
      end
   end
   logic start_edge;
   logic rd_end;
   logic host_read;
   assign start_edge = cvs && !cvs_q && standby_n_n;
   assign host_read = !cs_n && !rd_n;
   assign rd_end = rd_n && !rd_q && !cs_n;

   // ------------------------------------------------------------
   // software channel-select register
   // ------------------------------------------------------------
   logic [SEL_W-1:0] sw_sel;
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         sw_sel <= SEL_RESET;
      // store low data lines on write rising edge
      // bit 0 is channel 1 through bit 3 channel 4
      else if (wr_n && !wr_q && !cs_n && rd_n)
         sw_sel <= dl;
   end

   // ------------------------------------------------------------
   // master clock tick
   // ------------------------------------------------------------
   logic [3:0] div_cnt;
   logic int_tick;
   logic mclk_tick;
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i || div_cnt == INT_DIV_LAST)
         div_cnt <= '0;
      else
         div_cnt <= div_cnt + 1'b1;
   end
   assign int_tick = div_cnt == INT_DIV_LAST;
   // internal divider on 0, external clock rising edge on 1
   assign mclk_tick = cks ? (ext_clk && !ext_q) : int_tick;

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   seq_state_t state;
   logic [SEL_W-1:0] seq_mask;
   logic [SEL_W-1:0] pending;
   logic [1:0] cur_ch;
   logic [4:0] tick_cnt;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [DATA_W-1:0] fifo_out_data;
   logic [1:0] next_ch;

   always_comb
   begin
      next_ch = 2'h0;
      for (int i = NUM_CH - 1; i >= 0; i--)
         if (pending[i])
            next_ch = 2'(i);
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         state <= ST_IDLE;
         seq_mask <= '0;
         pending <= '0;
         cur_ch <= '0;
         tick_cnt <= '0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (start_edge)
               begin
                  // hardware pins when select is zero
                  // software register when select is one
                  seq_mask <= hs_sel ? sw_sel : hw_sel;
                  pending <= hs_sel ? sw_sel : hw_sel;
                  tick_cnt <= '0;
                  state <= ((hs_sel ? sw_sel : hw_sel) == '0) ? ST_IDLE
                     : ST_CONV;
               end
            end
            ST_CONV:
            begin
               cur_ch <= next_ch;
               if (mclk_tick)
               begin
                  if (tick_cnt == CONV_LAST)
                     state <= ST_STORE;
                  else
                     tick_cnt <= tick_cnt + 1'b1;
               end
            end
            ST_STORE:
            begin
               // a full FIFO stalls the sequence rather than drop data
               if (fifo_in_ready)
               begin
                  pending[cur_ch] <= 1'b0;
                  tick_cnt <= '0;
                  state <= ((pending & ~(SEL_W'(1) << cur_ch)) == '0)
                     ? ST_IDLE : ST_CONV;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   logic store_fire;
   assign store_fire = state == ST_STORE && fifo_in_ready;
   assign conv_sample_o = store_fire;
   assign conv_channel_o = cur_ch;
   assign busy_o = state != ST_IDLE;
   // all holds together for the sequence
   assign hold_o = state != ST_IDLE;
   assign power_down_o = !standby_n_n;

   // ------------------------------------------------------------
   // end-of-conversion pulse
   // ------------------------------------------------------------
   logic [3:0] eoc_cnt;
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         eoc_cnt <= '0;
      else if (store_fire)
         eoc_cnt <= EOC_LAST + 4'h1;
      else if (eoc_cnt != '0)
         eoc_cnt <= eoc_cnt - 1'b1;
   end
   assign eoc_n_o = eoc_cnt == '0;

   // ------------------------------------------------------------
   // result FIFO and read pointer
   // ------------------------------------------------------------
   sadc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .flush_i(start_edge && state == ST_IDLE),
      .in_valid_i(state == ST_STORE),
      .in_ready_o(fifo_in_ready),
      .in_data_i(adc_result_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(rd_end),
      .out_data_o(fifo_out_data)
   );

   logic [1:0] rd_ptr;
   logic [2:0] sel_count;
   always_comb
   begin
      sel_count = '0;
      for (int i = 0; i < NUM_CH; i++)
         sel_count = sel_count + 3'(seq_mask[i]);
   end
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         rd_ptr <= PTR_FIRST;
      else if (start_edge && state == ST_IDLE)
         rd_ptr <= PTR_FIRST;
      // each read moves on, wrapping after the last
      else if (rd_end)
         rd_ptr <= (3'(rd_ptr) + 3'h1 >= sel_count) ? PTR_FIRST
            : rd_ptr + 1'b1;
   end
   // flag high while pointer on the first result
   assign first_result_flag_o = rd_ptr == PTR_FIRST;

   // ------------------------------------------------------------
   // data bus drive
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         data_line_o <= '0;
      else if (host_read && rd_q)
         data_line_o <= fifo_out_valid ? fifo_out_data : '0;
   end
   // drive only while read and select both low
   assign data_line_oe_n_o = !host_read;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_busy_rises: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) start_edge && state == ST_IDLE && (hs_sel ? sw_sel
      : hw_sel) != '0 |=> busy_o)
      else $error("busy did not rise after start");
   a_first_flag: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) start_edge && state == ST_IDLE |=> first_result_flag_o)
      else $error("first flag disagrees with pointer");
   a_hold_start: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) busy_o |-> hold_o)
      else $error("hold not asserted while busy");
   a_mask_held: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) busy_o && $past(busy_o) |-> $stable(seq_mask))
      else $error("selection changed mid sequence");
   a_bus_drive: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) !data_line_oe_n_o |-> !cs_n && !rd_n)
      else $error("bus driven without read select");
   a_sel_write: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) wr_n && !wr_q && !cs_n && rd_n |=> sw_sel ==
      $past(dl))
      else $error("select register not written");
   a_conv_len: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) state == ST_CONV && tick_cnt == CONV_LAST && mclk_tick
      |=> state == ST_STORE)
      else $error("conversion length wrong");
   a_eoc_pulse: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) store_fire |=> !eoc_n_o [*8] ##1 !eoc_n_o [*2]
      ##1 eoc_n_o)
      else $error("eoc pulse width wrong");
   a_standby: assert property (@(posedge core_clk_i) disable iff
      (!reset_n_i) power_down_o == !standby_n_n)
      else $error("standby state wrong");
endmodule

// ==== sim/sadc_host_model.sv ====
// processor bus model: chip-select, read and write strobes, low data lines
// assumes the bench calls its tasks; it drives on the falling clock edge
`timescale 1ns/1ps
module sadc_host_model (
   input wire logic core_clk_i,
   input wire logic [11:0] data_line_i,
   input wire logic data_line_oe_n_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic [3:0] data_o
);
   initial
   begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      data_o = 4'h0;
   end

   task automatic write_sel(input logic [3:0] val, input logic sel_n);
      @(negedge core_clk_i);
      cs_n_o = sel_n;
      wr_n_o = 1'b0;
      data_o = val;
      repeat (4) @(negedge core_clk_i);
      wr_n_o = 1'b1;
      // hold past the synchroniser so the edge sees valid data
      repeat (4) @(negedge core_clk_i);
      cs_n_o = 1'b1;
      data_o = ~val;
   endtask

   task automatic read_word(input logic sel_n, output logic [11:0] val,
                            output logic oe_n);
      @(negedge core_clk_i);
      cs_n_o = sel_n;
      rd_n_o = 1'b0;
      repeat (5) @(negedge core_clk_i);
      val = data_line_i;
      oe_n = data_line_oe_n_i;
      rd_n_o = 1'b1;
      @(negedge core_clk_i);
      cs_n_o = 1'b1;
      repeat (5) @(negedge core_clk_i);
   endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the converter sequence control
// assumes the host model drives the strobes; the analog core is a formula
`timescale 1ns/1ps
module tb_top;
   import sadc_pkg::*;
   typedef struct {logic hs; logic cks; logic [3:0] hw; logic [3:0] sw;} row_t;
   logic core_clk_i = 1'b0;
   logic ext_clk = 1'b0;
   logic reset_n_i = 1'b0;
   logic convert_start_n_i = 1'b1;
   logic [3:0] hw_channel_select_i = 4'h0;
   logic hw_sw_select_i = 1'b0;
   logic standby_n_i = 1'b1;
   logic clock_source_select_i = 1'b0;
   logic cs_n, rd_n, wr_n, data_line_oe_n_o, busy_o, first_result_flag_o;
   logic eoc_n_o, hold_o, conv_sample_o, power_down_o, eoc_prev;
   logic [3:0] host_data;
   logic [1:0] conv_channel_o;
   logic [11:0] data_line_o, adc_result_i, val;
   logic oe;
   int n_errors = 0;
   int n_compared = 0;
   int n_eoc = 0;
   int n_busy = 0;
   row_t rows [6] = '{'{0, 0, 4'h5, 4'hA}, '{1, 0, 4'h5, 4'hA},
      '{0, 0, 4'hF, 4'h0}, '{0, 0, 4'h4, 4'h1}, '{0, 0, 4'h0, 4'hF},
      '{1, 1, 4'h2, 4'h8}};

   always #4 core_clk_i = ~core_clk_i;
   always #20 ext_clk = ~ext_clk;
   assign adc_result_i = 12'hA50 + {10'h000, conv_channel_o};

   always @(posedge core_clk_i)
   begin
      eoc_prev <= eoc_n_o;
      if (eoc_prev === 1'b1 && eoc_n_o === 1'b0)
         n_eoc <= n_eoc + 1;
      if (busy_o === 1'b1)
         n_busy <= n_busy + 1;
   end

   sadc_seq_ctrl sadc_seq_ctrl_inst (.core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i), .convert_start_n_i(convert_start_n_i),
      .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
      .hw_channel_select_i(hw_channel_select_i),
      .hw_sw_select_i(hw_sw_select_i), .standby_n_i(standby_n_i),
      .clock_source_select_i(clock_source_select_i),
      .external_conversion_clock_i(ext_clk), .data_line_i(host_data),
      .adc_result_i(adc_result_i), .data_line_o(data_line_o),
      .data_line_oe_n_o(data_line_oe_n_o), .busy_o(busy_o),
      .first_result_flag_o(first_result_flag_o), .eoc_n_o(eoc_n_o),
      .hold_o(hold_o), .conv_sample_o(conv_sample_o),
      .conv_channel_o(conv_channel_o), .power_down_o(power_down_o));

   sadc_host_model sadc_host_model_inst (.core_clk_i(core_clk_i),
      .data_line_i(data_line_o), .data_line_oe_n_i(data_line_oe_n_o),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(host_data));

   task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic run_seq(input logic [3:0] mask);
      logic first;
      int k;
      first = 1'b1;
      k = 0;
      n_eoc = 0;
      n_busy = 0;
      @(negedge core_clk_i);
      convert_start_n_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
      convert_start_n_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      // pins move mid-sequence; the captured selection must still rule
      hw_channel_select_i = ~hw_channel_select_i;
      check("busy", 12'(busy_o), 12'(mask != 4'h0));
      check("hold", 12'(hold_o), 12'(mask != 4'h0));
      while (busy_o !== 1'b0 && k < 2000)
      begin
         @(negedge core_clk_i);
         k++;
      end
      check("busy end", 12'(busy_o), 12'h000);
      repeat (14) @(negedge core_clk_i);
      check("eoc count", 12'(n_eoc), 12'($countones(mask)));
      if ($countones(mask) == 1 && !clock_source_select_i)
         check("conv len", 12'(n_busy >= 28 && n_busy <= 32), 12'h1);
      for (int c = 0; c < 4; c++)
         if (mask[c])
         begin
            check("first", 12'(first_result_flag_o), 12'(first));
            first = 1'b0;
            sadc_host_model_inst.read_word(1'b0, val, oe);
            check("data", val, 12'hA50 + 12'(c));
            check("oe_n", 12'(oe), 12'h000);
         end
      check("first wrap", 12'(first_result_flag_o), 12'h001);
   endtask

   initial
   begin
      #(20000 * 8);
      n_errors++;
      finish_test();
   end

   initial
   begin
      repeat (8) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge core_clk_i);
      check("rst busy", 12'(busy_o), 12'h000);
      check("rst eoc", 12'(eoc_n_o), 12'h001);
      check("rst oe", 12'(data_line_oe_n_o), 12'h001);
      check("rst flag", 12'(first_result_flag_o), 12'h001);
      foreach (rows[i])
      begin
         sadc_host_model_inst.write_sel(rows[i].sw, 1'b0);
         hw_sw_select_i = rows[i].hs;
         clock_source_select_i = rows[i].cks;
         hw_channel_select_i = rows[i].hw;
         repeat (4) @(negedge core_clk_i);
         run_seq(rows[i].hs ? rows[i].sw : rows[i].hw);
      end
      sadc_host_model_inst.write_sel(4'h3, 1'b1);
      run_seq(4'h8);
      sadc_host_model_inst.read_word(1'b1, val, oe);
      check("oe deselected", 12'(oe), 12'h001);
      standby_n_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      check("standby", 12'(power_down_o), 12'h001);
      run_seq(4'h0);
      standby_n_i = 1'b1;
      finish_test();
   end
endmodule
